// [core/cbs_scheduler.sv]
// Behaviour
// - with no air-initiated Comm-B, start: load buffer, show DR, start timer.
// - a running broadcast is never pre-empted by a newer one.
// - after 18 s expiry clear DR, drop message, toggle message number.
// - successive broadcasts alternate message numbers 1 and 2.
// - air-initiated Comm-B stops and resets timer, hides broadcast DR.
// - after air-initiated Comm-B ends, re-announce for another full 18 s.
// - broadcast DR codes only shown to interrogator codes not held by an air-initiated Comm-B.
// - waiting broadcasts wait until the current one has timed out.
// - a waiting broadcast is overwritten so only newest value goes out.
// - a waiting broadcast's timer starts only when it becomes current.
// - enhanced mode tracks interruption per interrogator code, up to 16.
// - enhanced mode: next broadcast only after all per-code timers expire.
// - flight ID entry triggers broadcast; unchanged re-entry does not.
// - capability report entry triggers broadcast; unchanged re-entry does not.
// - only capability report and flight ID use broadcast.
// - interrogators cannot cancel; only timer expiry ends a broadcast.
`timescale 1ns/1ps
module cbs_scheduler #(
  parameter int unsigned TICK_CYC = cbs_pkg::TICK_CYC,
  parameter int unsigned HOLD_TICKS = cbs_pkg::HOLD_TICKS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [cbs_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [cbs_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic air_any,
  input wire logic [cbs_pkg::LANES-1:0] air_ii,
  input wire logic rep_req,
  input wire logic [3:0] rep_ii,
  input wire logic [4:0] rep_rr,
  input wire logic [2:0] rep_di,
  input wire logic [3:0] rep_rrs,
  output logic rep_valid_reg,
  output logic [4:0] rep_dr_reg,
  output logic rep_mb_vld_reg,
  output logic [cbs_pkg::MB_W-1:0] rep_mb_reg,
  output logic [4:0] bcast_dr_reg
);
  logic wr_en;
  logic [cbs_pkg::ADDR_W-1:0] wr_addr;
  logic [cbs_pkg::ADDR_W-1:0] rd_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [31:0] rd_data;
  logic wr_ok;
  logic rd_ok;
  logic [31:0] ctrl_reg;
  logic [31:0] fid_lo_reg;
  logic [31:0] fid_hi_reg;
  logic [31:0] cap_lo_reg;
  logic [31:0] cap_hi_reg;
  cbs_pkg::cbs_state_t state_reg;
  logic msg_reg;
  logic src_reg;
  logic first_reg;
  logic [cbs_pkg::MB_W-1:0] cur_reg;
  logic [cbs_pkg::DIV_W-1:0] div_reg;
  logic tick;
  logic pend_reg [2];
  logic [cbs_pkg::MB_W-1:0] slot_reg [2];
  logic [cbs_pkg::MB_W-1:0] sent_reg [2];
  logic sent_vld_reg [2];
  logic [cbs_pkg::MB_W-1:0] stage [2];
  logic [1:0] commit;
  logic [1:0] diff;
  logic [1:0] new_p;
  logic [1:0] take;
  logic [cbs_pkg::LANES-1:0] hold;
  logic [cbs_pkg::LANES-1:0] done;
  logic [cbs_pkg::LANES-1:0] vis;
  logic [5:0] wa;
  logic [5:0] ra;

  cbs_axil_slave u_bus (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .wr_strb(wr_strb), .wr_ok(wr_ok),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_ok(rd_ok)
  );

  // word-aligned decode; low address bits are ignored
  assign wa = {wr_addr[5:2], 2'b00};
  assign ra = {rd_addr[5:2], 2'b00};
  assign wr_ok = wa <= cbs_pkg::OFS_LANE;
  assign rd_ok = ra <= cbs_pkg::OFS_LANE;
  wire enh = ctrl_reg[cbs_pkg::CTRL_ENH];
  wire acas = ctrl_reg[cbs_pkg::CTRL_ACAS];
  wire bcast = state_reg == cbs_pkg::CBS_BCAST;
  wire [31:0] stat = {26'h0, src_reg, pend_reg[1], pend_reg[0], first_reg, msg_reg, bcast};
  assign rd_data = ra == cbs_pkg::OFS_CTRL ? ctrl_reg :
                   ra == cbs_pkg::OFS_STAT ? stat :
                   ra == cbs_pkg::OFS_FID_LO ? fid_lo_reg :
                   ra == cbs_pkg::OFS_FID_HI ? {8'h00, fid_hi_reg[23:0]} :
                   ra == cbs_pkg::OFS_CAP_LO ? cap_lo_reg :
                   ra == cbs_pkg::OFS_CAP_HI ? {8'h00, cap_hi_reg[23:0]} :
                   ra == cbs_pkg::OFS_CUR_LO ? cur_reg[31:0] :
                   ra == cbs_pkg::OFS_CUR_HI ? {8'h00, cur_reg[55:32]} :
                   ra == cbs_pkg::OFS_LANE ? {16'h0000, done} : 32'h0000_0000;

  // staging registers; ENTRY is write-only and acts as the entry strobe
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg <= cbs_pkg::CTRL_RST;
      fid_lo_reg <= '0;
      fid_hi_reg <= '0;
      cap_lo_reg <= '0;
      cap_hi_reg <= '0;
    end
    else if (wr_en)
    begin
      if (wa == cbs_pkg::OFS_CTRL)
        ctrl_reg <= cbs_pkg::cbs_strb(ctrl_reg, wr_data, wr_strb) & 32'h0000_0003;
      if (wa == cbs_pkg::OFS_FID_LO)
        fid_lo_reg <= cbs_pkg::cbs_strb(fid_lo_reg, wr_data, wr_strb);
      if (wa == cbs_pkg::OFS_FID_HI)
        fid_hi_reg <= cbs_pkg::cbs_strb(fid_hi_reg, wr_data, wr_strb) & 32'h00FF_FFFF;
      if (wa == cbs_pkg::OFS_CAP_LO)
        cap_lo_reg <= cbs_pkg::cbs_strb(cap_lo_reg, wr_data, wr_strb);
      if (wa == cbs_pkg::OFS_CAP_HI)
        cap_hi_reg <= cbs_pkg::cbs_strb(cap_hi_reg, wr_data, wr_strb) & 32'h00FF_FFFF;
    end
  end

  // 1 ms enable for the hold timers
  assign tick = div_reg == cbs_pkg::DIV_W'(TICK_CYC - 1);
  always_ff @(posedge aclk)
  begin
    if (!aresetn || tick)
      div_reg <= '0;
    else
      div_reg <= div_reg + 1'b1;
  end

  // exactly two sources: 0 is flight id, 1 is capability report
  assign stage[0] = {fid_hi_reg[23:0], fid_lo_reg};
  assign stage[1] = {cap_hi_reg[23:0], cap_lo_reg};
  wire in_air = enh ? |air_ii : air_any;
  wire both = pend_reg[0] && pend_reg[1];
  wire sel = both ? first_reg : pend_reg[1];
  // no start in a cycle with an entry, so compare and load never race
  wire start = !bcast && (pend_reg[0] || pend_reg[1]) && !in_air && commit == 2'b00;
  wire all_done = &done;
  wire fin = bcast && all_done;

  for (genvar s = 0; s < 2; s++)
  begin : g_src
    assign commit[s] = wr_en && wa == cbs_pkg::OFS_ENTRY && wr_strb[0] && wr_data[s];
    assign diff[s] = !sent_vld_reg[s] || stage[s] != sent_reg[s];
    assign new_p[s] = commit[s] && !pend_reg[s] && diff[s];
    assign take[s] = start && sel == s;
    // a waiting entry is overwritten in place and keeps its turn
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        pend_reg[s] <= 1'b0;
        slot_reg[s] <= '0;
        sent_reg[s] <= '0;
        sent_vld_reg[s] <= 1'b0;
      end
      else
      begin
        if (commit[s] && (pend_reg[s] || diff[s]))
        begin
          pend_reg[s] <= 1'b1;
          slot_reg[s] <= stage[s];
        end
        else if (take[s])
          pend_reg[s] <= 1'b0;
        if (take[s])
        begin
          sent_reg[s] <= slot_reg[s];
          sent_vld_reg[s] <= 1'b1;
        end
      end
    end
  end

  // remember the last source to begin waiting while the other was not; 0 on a tie
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      first_reg <= 1'b0;
    else if (new_p[0] && !pend_reg[1])
      first_reg <= 1'b0;
    else if (new_p[1] && !pend_reg[0] && !new_p[0])
      first_reg <= 1'b1;
  end

  // broadcast sequencer; nothing but expiry leaves the broadcast state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= cbs_pkg::CBS_IDLE;
      msg_reg <= 1'b0;
      src_reg <= 1'b0;
      cur_reg <= '0;
    end
    else
    begin
      unique case (state_reg)
        cbs_pkg::CBS_IDLE:
        begin
          if (start)
          begin
            state_reg <= cbs_pkg::CBS_BCAST;
            cur_reg <= slot_reg[sel];
            src_reg <= sel;
          end
        end
        cbs_pkg::CBS_BCAST:
        begin
          if (fin)
          begin
            state_reg <= cbs_pkg::CBS_IDLE;
            cur_reg <= '0;
            msg_reg <= !msg_reg;
          end
        end
      endcase
    end
  end

  // one timer per interrogator code; legacy mode holds all on the global flag
  for (genvar i = 0; i < cbs_pkg::LANES; i++)
  begin : g_lane
    assign hold[i] = enh ? air_ii[i] : air_any;
    assign vis[i] = bcast && !done[i] && !hold[i];
    cbs_hold_timer #(.HOLD(HOLD_TICKS)) u_tmr (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(tick),
      .start(start),
      .hold(hold[i]),
      .done_reg(done[i])
    );
  end

  wire [4:0] dr_code = {2'b00, cbs_pkg::DR_BCAST_BASE[2], acas, msg_reg};
  wire di_plain = rep_di != cbs_pkg::DI_SPECIAL_A && rep_di != cbs_pkg::DI_SPECIAL_B;
  wire ext_ok = rep_rr == cbs_pkg::RR_BCAST && (di_plain || rep_rrs == cbs_pkg::RRS_BCAST);
  wire ext = vis[rep_ii] && ext_ok;

  // reply fields, answered one cycle after the request
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rep_valid_reg <= 1'b0;
      rep_dr_reg <= '0;
      rep_mb_vld_reg <= 1'b0;
      rep_mb_reg <= '0;
      bcast_dr_reg <= '0;
    end
    else
    begin
      rep_valid_reg <= rep_req;
      rep_dr_reg <= rep_req && vis[rep_ii] ? dr_code : 5'h00;
      rep_mb_vld_reg <= rep_req && ext;
      rep_mb_reg <= rep_req && ext ? cur_reg : '0;
      bcast_dr_reg <= bcast && !in_air ? dr_code : 5'h00;
    end
  end

  // number used by the previous broadcast, so that a repeated number is caught at the next start
  logic last_msg_reg;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      last_msg_reg <= 1'b1;
    else if (start)
      last_msg_reg <= msg_reg;
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_extract;
    rep_req && vis[rep_ii] && ext_ok;
  endsequence
  sequence s_begin;
    start ##1 !in_air;
  endsequence

  a_start_announce: assert property (s_begin |=> bcast_dr_reg[2] && bcast_dr_reg[0] == msg_reg)
    else $error("broadcast start not announced");
  a_no_preempt: assert property (bcast && !fin |=> bcast && $stable(cur_reg))
    else $error("running broadcast changed");
  a_expiry_toggle: assert property (fin |=> !bcast && cur_reg == '0 && msg_reg != $past(msg_reg))
    else $error("expiry did not clear and toggle");
  a_alt_number: assert property (start |-> msg_reg != last_msg_reg)
    else $error("message number not alternate");
  a_hold_stops: assert property (bcast && hold[0] && !done[0] |=> !done[0])
    else $error("timer ran while held");
  a_air_hides_dr: assert property (rep_req && hold[rep_ii] |=> rep_dr_reg == 5'h00)
    else $error("broadcast DR shown during air-initiated");
  a_queue_waits: assert property (bcast && !all_done |=> bcast)
    else $error("broadcast left before expiry");
  a_newest_kept: assert property (commit[0] && pend_reg[0] |=> slot_reg[0] == $past(stage[0]))
    else $error("waiting value not overwritten");
  a_timer_fresh: assert property (start |=> done == '0)
    else $error("timers not started with broadcast");
  a_no_repeat: assert property (commit[1] && !pend_reg[1] && !diff[1] |=> !pend_reg[1])
    else $error("unchanged report queued again");
  a_extract_mb: assert property (s_extract |=> rep_mb_vld_reg && rep_mb_reg == $past(cur_reg))
    else $error("MB not returned on extraction");
endmodule

// [core/cbs_pkg.sv]
package cbs_pkg;
  // clock and timing
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYC = TICK_US * CLK_MHZ;
  localparam int unsigned HOLD_S = 18;
  localparam int unsigned HOLD_TICKS = HOLD_S * 1000000 / TICK_US;
  localparam int unsigned CNT_W = 15;
  localparam int unsigned DIV_W = 18;
  localparam int unsigned LANES = 16;
  localparam int unsigned MB_W = 56;
  // register map, byte addresses
  localparam int unsigned ADDR_W = 6;
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_STAT = 6'h04;
  localparam logic [5:0] OFS_FID_LO = 6'h08;
  localparam logic [5:0] OFS_FID_HI = 6'h0C;
  localparam logic [5:0] OFS_CAP_LO = 6'h10;
  localparam logic [5:0] OFS_CAP_HI = 6'h14;
  localparam logic [5:0] OFS_ENTRY = 6'h18;
  localparam logic [5:0] OFS_CUR_LO = 6'h1C;
  localparam logic [5:0] OFS_CUR_HI = 6'h20;
  localparam logic [5:0] OFS_LANE = 6'h24;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // field positions
  localparam int unsigned CTRL_ENH = 0;
  localparam int unsigned CTRL_ACAS = 1;
  // downlink codes and extraction request
  localparam logic [2:0] DR_BCAST_BASE = 3'h4;
  localparam logic [4:0] RR_BCAST = 5'h10;
  localparam logic [2:0] DI_SPECIAL_A = 3'h3;
  localparam logic [2:0] DI_SPECIAL_B = 3'h7;
  localparam logic [3:0] RRS_BCAST = 4'h0;
  typedef enum logic [0:0] {CBS_IDLE = 1'b0, CBS_BCAST = 1'b1} cbs_state_t;
  // merge a bus write into a register under byte strobes
  function automatic logic [31:0] cbs_strb(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
    cbs_strb = old;
    for (int b = 0; b < 4; b++)
    begin
      if (s[b])
        cbs_strb[8*b +: 8] = nw[8*b +: 8];
    end
  endfunction
endpackage

// [core/cbs_hold_timer.sv]
`timescale 1ns/1ps
module cbs_hold_timer #(
  parameter int unsigned HOLD = cbs_pkg::HOLD_TICKS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input wire logic start,
  input wire logic hold,
  output logic done_reg
);
  logic [cbs_pkg::CNT_W-1:0] cnt_reg;
  localparam logic [cbs_pkg::CNT_W-1:0] LAST = cbs_pkg::CNT_W'(HOLD - 1);
  // a hold stops and clears the count, so release restarts a full period
  always_ff @(posedge aclk)
  begin
    if (!aresetn || start || (hold && !done_reg))
      cnt_reg <= '0;
    else if (tick && !done_reg)
      cnt_reg <= cnt_reg + 1'b1;
  end
  // done is sticky until the next broadcast starts
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      done_reg <= 1'b1;
    else if (start)
      done_reg <= 1'b0;
    else if (tick && !hold && cnt_reg == LAST)
      done_reg <= 1'b1;
  end
endmodule

// [core/cbs_axil_slave.sv]
`timescale 1ns/1ps
module cbs_axil_slave (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [cbs_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [cbs_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_en,
  output logic [cbs_pkg::ADDR_W-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  output logic [cbs_pkg::ADDR_W-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);
  // address and data are held until both are in and the response is free
  assign wr_en = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign rd_addr = s_axi_araddr;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= cbs_pkg::RESP_OKAY;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        wr_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      else if (wr_en)
        s_axi_awready <= 1'b1;
      if (s_axi_wvalid && s_axi_wready)
      begin
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      else if (wr_en)
        s_axi_wready <= 1'b1;
      if (wr_en)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? cbs_pkg::RESP_OKAY : cbs_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end
  // one read in flight; data captured on the address handshake
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= cbs_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_ok ? cbs_pkg::RESP_OKAY : cbs_pkg::RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule

// [tb/cbs_interrogator.sv]
`timescale 1ns/1ps
// ground interrogator: only extracts, it has no way to start or cancel a broadcast
module cbs_interrogator (
  input wire logic aclk,
  output logic rep_req,
  output logic [3:0] rep_ii,
  output logic [4:0] rep_rr,
  output logic [2:0] rep_di,
  output logic [3:0] rep_rrs,
  input wire logic rep_valid_reg,
  input wire logic [4:0] rep_dr_reg,
  input wire logic rep_mb_vld_reg,
  input wire logic [55:0] rep_mb_reg
);
  // fields mean nothing outside a request, so they are scrambled there
  initial
  begin
    rep_req = 1'b0;
    rep_ii = 4'h5;
    rep_rr = 5'h0A;
    rep_di = 3'h5;
    rep_rrs = 4'hA;
  end

  // one interrogation; the reply stands one cycle, so it is sampled just after its edge
  task ask(input logic [3:0] ii, input logic [4:0] rr, input logic [2:0] di, input logic [3:0] rrs,
           output logic [4:0] dr, output logic mv, output logic [55:0] mb);
    int n;
    n = 0;
    @(posedge aclk);
    rep_req <= 1'b1;
    rep_ii <= ii;
    rep_rr <= rr;
    rep_di <= di;
    rep_rrs <= rrs;
    @(posedge aclk);
    rep_req <= 1'b0;
    rep_ii <= ~ii;
    rep_rr <= ~rr;
    rep_di <= ~di;
    rep_rrs <= ~rrs;
    #1;
    while (rep_valid_reg !== 1'b1 && n < 8)
    begin
      @(posedge aclk);
      #1;
      n++;
    end
    dr = rep_dr_reg;
    mv = rep_mb_vld_reg;
    mb = rep_mb_reg;
  endtask
endmodule

// [tb/test_commb_broadcast_scheduler.sv]
`timescale 1ns/1ps
module test_commb_broadcast_scheduler;
  localparam int TC = 4;
  localparam int HT = 20;
  localparam int LO = (HT - 1) * TC;
  localparam int HI = (HT + 1) * TC + 4;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [5:0] s_axi_awaddr = 6'h00;
  logic [5:0] s_axi_araddr = 6'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic air_any = 1'b0;
  logic [15:0] air_ii = 16'h0000;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic rep_req, rep_valid_reg, rep_mb_vld_reg;
  logic [3:0] rep_ii, rep_rrs;
  logic [4:0] rep_rr, rep_dr_reg, bcast_dr_reg;
  logic [2:0] rep_di;
  logic [55:0] rep_mb_reg, fa, fb, fc, fd;
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  int t0 = 0;

  always #2 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;

  cbs_scheduler #(.TICK_CYC(TC), .HOLD_TICKS(HT)) cbs_scheduler_inst (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .air_any, .air_ii, .rep_req, .rep_ii, .rep_rr, .rep_di, .rep_rrs,
    .rep_valid_reg, .rep_dr_reg, .rep_mb_vld_reg, .rep_mb_reg, .bcast_dr_reg);

  cbs_interrogator cbs_interrogator_inst (.aclk, .rep_req, .rep_ii, .rep_rr, .rep_di, .rep_rrs,
    .rep_valid_reg, .rep_dr_reg, .rep_mb_vld_reg, .rep_mb_reg);

  // expected announcement code from the acas flag and the message number
  function automatic logic [4:0] dr_exp(input logic acas, input logic msg2);
    dr_exp = cbs_pkg::DR_BCAST_BASE + 5'(2 * acas) + 5'(msg2);
  endfunction

  task complete_run;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  // hold time is one tick coarse either way, plus a few cycles of pipeline
  task chk_len(input int got, input string what);
    checked++;
    if (got < LO || got > HI)
    begin
      n_fail++;
      $display("wrong value at %0t: %s lasted %0d cycles", $time, what, got);
    end
  endtask

  // aw and w offered together, each released at its own handshake
  task wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done && n < 200)
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready)
      begin
        done = 1'b1;
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er, "write response");
      end
    end
    chk(done, 1'b1, "write finished");
  endtask

  task rd(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done && n < 200)
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready)
      begin
        done = 1'b1;
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, ed, "read data");
        chk(s_axi_rresp, er, "read response");
      end
    end
    chk(done, 1'b1, "read finished");
  endtask

  // a peripheral loads a source value and commits it: src 0 flight id, 1 capability
  task put(input logic src, input logic [55:0] v);
    wr(src ? cbs_pkg::OFS_CAP_LO : cbs_pkg::OFS_FID_LO, v[31:0], cbs_pkg::RESP_OKAY);
    wr(src ? cbs_pkg::OFS_CAP_HI : cbs_pkg::OFS_FID_HI, {8'h00, v[55:32]}, cbs_pkg::RESP_OKAY);
    wr(cbs_pkg::OFS_ENTRY, src ? 32'h2 : 32'h1, cbs_pkg::RESP_OKAY);
  endtask

  task ext(input logic [3:0] ii, input logic [4:0] rr, input logic [2:0] di, input logic [3:0] rrs,
           input logic [4:0] edr, input logic emv, input logic [55:0] emb);
    logic [4:0] dr;
    logic mv;
    logic [55:0] mb;
    cbs_interrogator_inst.ask(ii, rr, di, rrs, dr, mv, mb);
    chk(dr, edr, "reply code");
    chk(mv, emv, "message valid");
    chk(mb, emv ? emb : 56'h0, "message field");
  endtask

  task wait_dr(input logic [4:0] v);
    int n;
    n = 0;
    while (bcast_dr_reg !== v && n < 300)
    begin
      @(posedge aclk);
      n++;
    end
    chk(bcast_dr_reg, v, "announcement code");
    t0 = cyc;
  endtask

  task hold_end(input logic [4:0] v);
    int n;
    n = 0;
    while (bcast_dr_reg === v && n < 300)
    begin
      @(posedge aclk);
      n++;
    end
    chk_len(cyc - t0, "broadcast");
  endtask

  // a hang is cut short well beyond the several hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    complete_run;
  end

  initial
  begin
    void'($urandom(33678));
    fa = {24'($urandom), $urandom};
    fb = {24'($urandom), $urandom};
    fc = {24'($urandom), $urandom};
    fd = {24'($urandom), $urandom};
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(cbs_pkg::OFS_CTRL, cbs_pkg::CTRL_RST, cbs_pkg::RESP_OKAY);
    rd(6'h28, 32'h0, cbs_pkg::RESP_SLVERR);
    wr(6'h2C, $urandom, cbs_pkg::RESP_SLVERR);
    chk(bcast_dr_reg, 5'h00, "idle code");
    $display("test reset and bus done");
    // queued sources: first served, others wait, newest flight id wins
    put(1'b0, fa);
    wait_dr(dr_exp(1'b0, 1'b0));
    ext(4'h0, cbs_pkg::RR_BCAST, 3'h0, 4'hF, dr_exp(1'b0, 1'b0), 1'b1, fa);
    ext(4'h1, cbs_pkg::RR_BCAST, cbs_pkg::DI_SPECIAL_A, cbs_pkg::RRS_BCAST, 5'h04, 1'b1, fa);
    ext(4'h2, cbs_pkg::RR_BCAST, cbs_pkg::DI_SPECIAL_B, 4'h1, 5'h04, 1'b0, 56'h0);
    ext(4'h3, 5'h00, 3'h0, 4'h0, 5'h04, 1'b0, 56'h0);
    put(1'b1, fc);
    put(1'b0, fb);
    put(1'b0, fd);
    hold_end(dr_exp(1'b0, 1'b0));
    wait_dr(dr_exp(1'b0, 1'b1));
    ext(4'h0, cbs_pkg::RR_BCAST, 3'h0, 4'h0, dr_exp(1'b0, 1'b1), 1'b1, fc);
    hold_end(dr_exp(1'b0, 1'b1));
    wait_dr(dr_exp(1'b0, 1'b0));
    ext(4'h0, cbs_pkg::RR_BCAST, 3'h0, 4'h0, dr_exp(1'b0, 1'b0), 1'b1, fd);
    hold_end(dr_exp(1'b0, 1'b0));
    $display("test queued broadcasts done");
    // unchanged re-entry is ignored, a changed report is sent
    wr(cbs_pkg::OFS_ENTRY, 32'h1, cbs_pkg::RESP_OKAY);
    wr(cbs_pkg::OFS_ENTRY, 32'h2, cbs_pkg::RESP_OKAY);
    repeat (20) @(posedge aclk);
    chk(bcast_dr_reg, 5'h00, "no rebroadcast");
    wr(cbs_pkg::OFS_CTRL, 32'h2, cbs_pkg::RESP_OKAY);
    put(1'b1, fb);
    wait_dr(dr_exp(1'b1, 1'b1));
    $display("test re-entry done");
    // air-initiated transfer interrupts at a random point
    repeat ($urandom_range(5, 30)) @(posedge aclk);
    air_any <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(bcast_dr_reg, 5'h00, "code during air transfer");
    ext(4'h0, cbs_pkg::RR_BCAST, 3'h0, 4'h0, 5'h00, 1'b0, 56'h0);
    repeat (HI + 10) @(posedge aclk);
    air_any <= 1'b0;
    wait_dr(dr_exp(1'b1, 1'b1));
    ext(4'h0, cbs_pkg::RR_BCAST, 3'h0, 4'h0, dr_exp(1'b1, 1'b1), 1'b1, fb);
    hold_end(dr_exp(1'b1, 1'b1));
    $display("test air interrupt done");
    // enhanced mode: one interrogator code held, the others keep the broadcast
    wr(cbs_pkg::OFS_CTRL, 32'h3, cbs_pkg::RESP_OKAY);
    put(1'b0, fa);
    wait_dr(dr_exp(1'b1, 1'b0));
    air_ii <= 16'h0004;
    repeat (3) @(posedge aclk);
    ext(4'h2, cbs_pkg::RR_BCAST, 3'h0, 4'h0, 5'h00, 1'b0, 56'h0);
    ext(4'h9, cbs_pkg::RR_BCAST, 3'h0, 4'h0, dr_exp(1'b1, 1'b0), 1'b1, fa);
    repeat (HI + 10) @(posedge aclk);
    air_ii <= 16'h0000;
    t0 = cyc;
    repeat (LO - 8) @(posedge aclk);
    ext(4'h2, cbs_pkg::RR_BCAST, 3'h0, 4'h0, dr_exp(1'b1, 1'b0), 1'b1, fa);
    hold_end(dr_exp(1'b1, 1'b0));
    $display("test enhanced mode done");
    complete_run;
  end
endmodule
